// [rtl/esf_dev.sv]
`timescale 1ns/1ps
`include "esf_regs.svh"
// ==========================================================================
module esf_dev
   import esf_pkg::*;
(
   input  wire logic      hclk,
   input  wire logic      hresetn,
   esf_spi_if.dev         spi,
   output      esf_byte_t rx_byte,
   output      logic      rx_valid,
   output      logic      rx_first,
   output      logic      sel_start,
   output      logic      sel_end,
   output      logic      selected,
   output      logic      held,
   output      logic      standby,
   input  wire esf_byte_t tx_byte,
   input  wire logic      tx_start,
   output      logic      tx_take,
   input  wire logic      wel_set,
   input  wire logic      wel_clr,
   input  wire logic      busy_set,
   input  wire logic      busy_clr,
   output      logic      write_enable_latch,
   output      logic      write_busy_flag,
   input  wire logic      status_write_disable,
   input  wire logic      protect_sel_hi,
   input  wire logic      protect_sel_lo,
   input  wire logic [1:0] wr_addr_hi,
   output      logic      wr_blocked,
   output      logic      status_locked
);
   // ========================================================================
   // declarations
   logic [4:0] s1_q;
   logic [4:0] s2_q;
   logic       sck_p_q;
   logic       hold_p_q;
   logic       sck_s;
   logic       cs_n_s;
   logic       mosi_s;
   logic       hold_n_s;
   logic       wp_n_s;
   logic       sck_rise;
   logic       sck_fall;
   logic       live;
   logic       armed_q;
   logic       sel_q;
   logic       sel_start_q;
   logic       sel_end_q;
   logic       hold_q;
   logic [2:0] bit_cnt_q;
   logic [6:0] rx_sh_q;
   logic       first_q;
   esf_byte_t  rx_byte_q;
   logic       rx_valid_q;
   logic       rx_first_q;
   logic       tx_arm_q;
   logic       drv_q;
   logic [2:0] out_cnt_q;
   logic [6:0] out_sh_q;
   logic       miso_q;
   logic       tx_take_q;
   logic       wel_q;
   logic       busy_q;
   logic       locked_q;
   logic       blocked_q;

   // ========================================================================
   // protected region decode
   function automatic logic protect_hit(input logic [1:0] sel, input logic [1:0] a_hi);
      logic hit;
      hit = 1'b0;
      unique case (sel)
         2'b00: hit = 1'b0;
         2'b01: hit = (a_hi == 2'b11);
         2'b10: hit = a_hi[1];
         2'b11: hit = 1'b1;
      endcase
      return hit;
   endfunction : protect_hit

   // ========================================================================
   // pin synchronisers; select reads as low until a real high is seen
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         s1_q     <= 5'h00;
         s2_q     <= 5'h00;
         sck_p_q  <= 1'b0;
         hold_p_q <= 1'b0;
      end else begin
         s1_q     <= {spi.wp_n, spi.hold_n, spi.mosi, spi.cs_n, spi.sck};
         s2_q     <= s1_q;
         sck_p_q  <= sck_s;
         hold_p_q <= hold_n_s;
      end
   end

   assign sck_s    = s2_q[0];
   assign cs_n_s   = s2_q[1];
   assign mosi_s   = s2_q[2];
   assign hold_n_s = s2_q[3];
   assign wp_n_s   = s2_q[4];
   assign sck_rise = sck_s & ~sck_p_q;
   assign sck_fall = ~sck_s & sck_p_q;
   assign live     = sel_q & ~hold_q;

   // ========================================================================
   // selection
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         armed_q     <= 1'b0;
         sel_q       <= 1'b0;
         sel_start_q <= 1'b0;
         sel_end_q   <= 1'b0;
      end else begin
         sel_start_q <= ~cs_n_s & armed_q & ~sel_q;
         sel_end_q   <= cs_n_s & sel_q;
         if (cs_n_s) begin
            armed_q <= 1'b1;
            sel_q   <= 1'b0;
         end else if (armed_q) begin
            sel_q <= 1'b1;
         end
      end
   end

   // ========================================================================
   // pause; a deselect while paused also ends the pause
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hold_q <= 1'b0;
      end else if (!sel_q || cs_n_s) begin
         hold_q <= 1'b0;
      end else if (!hold_q && hold_p_q && !hold_n_s && !sck_s) begin
         hold_q <= 1'b1;
      end else if (hold_q && hold_n_s && !sck_s) begin
         hold_q <= 1'b0;
      end
   end

   // ========================================================================
   // input shifter
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         bit_cnt_q  <= 3'h0;
         rx_sh_q    <= 7'h00;
         first_q    <= 1'b1;
         rx_byte_q  <= 8'h00;
         rx_valid_q <= 1'b0;
         rx_first_q <= 1'b0;
      end else if (!sel_q) begin
         bit_cnt_q  <= 3'h0;
         first_q    <= 1'b1;
         rx_valid_q <= 1'b0;
      end else begin
         rx_valid_q <= 1'b0;
         if (live && sck_rise) begin
            rx_sh_q   <= {rx_sh_q[5:0], mosi_s};
            bit_cnt_q <= 3'(bit_cnt_q + 3'h1);
            if (bit_cnt_q == 3'h7) begin
               rx_byte_q  <= {rx_sh_q, mosi_s};
               rx_valid_q <= 1'b1;
               rx_first_q <= first_q;
               first_q    <= 1'b0;
            end
         end
      end
   end

   // ========================================================================
   // output shifter; user starts it once a read-type byte is decoded
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         tx_arm_q  <= 1'b0;
         drv_q     <= 1'b0;
         out_cnt_q <= 3'h0;
         out_sh_q  <= 7'h00;
         miso_q    <= 1'b0;
         tx_take_q <= 1'b0;
      end else if (!sel_q) begin
         tx_arm_q  <= 1'b0;
         drv_q     <= 1'b0;
         out_cnt_q <= 3'h0;
         tx_take_q <= 1'b0;
      end else begin
         tx_take_q <= 1'b0;
         if (tx_start) begin
            tx_arm_q <= 1'b1;
         end
         if (live && sck_fall && tx_arm_q) begin
            if (out_cnt_q == 3'h0) begin
               miso_q    <= tx_byte[7];
               out_sh_q  <= tx_byte[6:0];
               out_cnt_q <= 3'h7;
               tx_take_q <= 1'b1;
               drv_q     <= 1'b1;
            end else begin
               miso_q    <= out_sh_q[6];
               out_sh_q  <= {out_sh_q[5:0], 1'b0};
               out_cnt_q <= 3'(out_cnt_q - 3'h1);
            end
         end
      end
   end

   assign spi.miso_oe = drv_q & sel_q & ~hold_q;
   assign spi.miso    = miso_q;

   // ========================================================================
   // volatile status; a set in the clearing cycle wins
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wel_q  <= 1'b0;
         busy_q <= 1'b0;
      end else begin
         if (wel_set) begin
            wel_q <= 1'b1;
         end else if (wel_clr) begin
            wel_q <= 1'b0;
         end
         if (busy_set) begin
            busy_q <= 1'b1;
         end else if (busy_clr) begin
            busy_q <= 1'b0;
         end
      end
   end

   // ========================================================================
   // protection; non-volatile bits live outside so reset cannot touch them
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         locked_q  <= 1'b0;
         blocked_q <= 1'b0;
      end else begin
         locked_q  <= status_write_disable & ~wp_n_s;
         blocked_q <= protect_hit({protect_sel_hi, protect_sel_lo}, wr_addr_hi);
      end
   end

   assign rx_byte            = rx_byte_q;
   assign rx_valid           = rx_valid_q;
   assign rx_first           = rx_first_q;
   assign sel_start          = sel_start_q;
   assign sel_end            = sel_end_q;
   assign selected           = sel_q;
   assign held               = hold_q;
   assign standby            = ~sel_q & ~busy_q;
   assign tx_take            = tx_take_q;
   assign write_enable_latch = wel_q;
   assign write_busy_flag    = busy_q;
   assign wr_blocked         = blocked_q;
   assign status_locked      = locked_q;
endmodule : esf_dev

// [rtl/esf_fifo.sv]
`timescale 1ns/1ps
module esf_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 32
) (
   input  wire logic             hclk,
   input  wire logic             hresetn,
   input  wire logic             in_valid,
   output      logic             in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output      logic             out_valid,
   input  wire logic             out_ready,
   output      logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW-1:0]    wr_q;
   logic [AW-1:0]    rd_q;
   logic [AW:0]      cnt_q;
   logic             push;
   logic             pop;

   // ========================================================================
   // flags
   assign in_ready  = (cnt_q != (AW+1)'(DEPTH));
   assign out_valid = (cnt_q != '0);
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;
   assign out_data  = mem_q[rd_q];

   // ========================================================================
   // storage
   always_ff @(posedge hclk) begin
      if (push) begin
         mem_q[wr_q] <= in_data;
      end
   end

   // ========================================================================
   // pointers; depth need not be a power of two
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else begin
         if (push) begin
            wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : AW'(wr_q + 1'b1);
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : AW'(rd_q + 1'b1);
         end
         if (push && !pop) begin
            cnt_q <= (AW+1)'(cnt_q + 1'b1);
         end else if (pop && !push) begin
            cnt_q <= (AW+1)'(cnt_q - 1'b1);
         end
      end
   end
endmodule : esf_fifo

// [rtl/esf_host.sv]
`timescale 1ns/1ps
`include "esf_regs.svh"
module esf_host
   import esf_pkg::*;
#(
   parameter int FIFO_DEPTH = `ESF_FIFO_DEPTH
) (
   input  wire logic        hclk,
   input  wire logic        hresetn,
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic [31:0] hwdata,
   input  wire logic        hready,
   output      logic        hreadyout,
   output      logic        hresp,
   output      logic [31:0] hrdata,
   esf_spi_if.host          spi
);
   // ========================================================================
   // declarations
   logic        ap_act_q;
   logic        ap_wr_q;
   logic [7:0]  ap_addr_q;
   logic [31:0] ctrl_q;
   logic [31:0] hrdata_q;
   logic        wr_pend;
   logic        tx_stall;
   logic        accept;
   logic        f_in_ready;
   logic        f_out_valid;
   logic        f_out_ready;
   esf_byte_t   f_out_data;
   esf_eng_t    st_q;
   logic [7:0]  cnt_q;
   logic [7:0]  half_m1;
   logic [2:0]  bit_q;
   esf_byte_t   sh_q;
   esf_byte_t   rx_q;
   esf_byte_t   rx_byte_q;
   logic        rx_rdy_q;
   logic        rx_done;
   logic        ms1_q;
   logic        ms2_q;
   logic        sck_q;
   logic        cs_n_q;
   logic        mosi_q;
   logic        hold_n_q;
   logic        wp_n_q;
   logic        paused;

   // ========================================================================
   // bus slave; a data write to a full fifo waits in the data phase
   assign accept    = hsel & htrans[1] & hready;
   assign wr_pend   = ap_act_q & ap_wr_q;
   assign tx_stall  = wr_pend & (ap_addr_q == `ESF_TXD_OFS) & ~f_in_ready;
   assign hreadyout = ~tx_stall;
   assign hresp     = 1'b0;
   assign hrdata    = hrdata_q;

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ap_act_q  <= 1'b0;
         ap_wr_q   <= 1'b0;
         ap_addr_q <= 8'h00;
      end else if (accept) begin
         ap_act_q  <= 1'b1;
         ap_wr_q   <= hwrite;
         ap_addr_q <= haddr[7:0];
      end else if (hready) begin
         ap_act_q  <= 1'b0;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         ctrl_q <= `ESF_CTRL_RST;
      end else if (wr_pend && ap_addr_q == `ESF_CTRL_OFS) begin
         ctrl_q <= hwdata & `ESF_CTRL_MASK;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hrdata_q <= 32'h00000000;
      end else if (accept && !hwrite) begin
         hrdata_q <= 32'h00000000;
         unique case (haddr[7:0])
            `ESF_CTRL_OFS: hrdata_q <= ctrl_q;
            `ESF_STAT_OFS: begin
               hrdata_q[`ESF_STAT_BUSY]  <= f_out_valid | (st_q != ESF_IDLE);
               hrdata_q[`ESF_STAT_EMPTY] <= ~f_out_valid;
               hrdata_q[`ESF_STAT_FULL]  <= ~f_in_ready;
               hrdata_q[`ESF_STAT_RXRDY] <= rx_rdy_q;
            end
            `ESF_RXD_OFS:  hrdata_q[7:0] <= rx_byte_q;
            default:       hrdata_q <= 32'h00000000;
         endcase
      end
   end

   // received byte flag: a byte landing in the reading cycle keeps it set
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         rx_rdy_q  <= 1'b0;
         rx_byte_q <= 8'h00;
      end else if (rx_done) begin
         rx_rdy_q  <= 1'b1;
         rx_byte_q <= rx_q;
      end else if (accept && !hwrite && haddr[7:0] == `ESF_RXD_OFS) begin
         rx_rdy_q  <= 1'b0;
      end
   end

   // ========================================================================
   // transmit queue
   esf_fifo #(.WIDTH(8), .DEPTH(FIFO_DEPTH)) u_fifo (
      .hclk      (hclk),
      .hresetn   (hresetn),
      .in_valid  (wr_pend && ap_addr_q == `ESF_TXD_OFS),
      .in_ready  (f_in_ready),
      .in_data   (hwdata[7:0]),
      .out_valid (f_out_valid),
      .out_ready (f_out_ready),
      .out_data  (f_out_data)
   );

   // ========================================================================
   // pins; select and protect change only between bytes
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         cs_n_q   <= 1'b1;
         wp_n_q   <= 1'b1;
         hold_n_q <= 1'b1;
         ms1_q    <= 1'b0;
         ms2_q    <= 1'b0;
      end else begin
         // released line reads as pulled up, never as the last driven bit
         ms1_q <= spi.miso_oe ? spi.miso : 1'b1;
         ms2_q <= ms1_q;
         if (st_q == ESF_IDLE) begin
            cs_n_q <= ~ctrl_q[`ESF_CTRL_CS];
         end
         if (st_q == ESF_IDLE && cs_n_q) begin
            wp_n_q <= ctrl_q[`ESF_CTRL_WP];
         end
         if (cs_n_q) begin
            hold_n_q <= 1'b1;
         end else if (!sck_q) begin
            hold_n_q <= ~ctrl_q[`ESF_CTRL_HOLD];
         end
      end
   end

   // ========================================================================
   // shift engine: each bit is a low half then a high half
   assign half_m1     = (ctrl_q[`ESF_CTRL_DIV_HI:`ESF_CTRL_DIV_LO] == 8'h00) ? 8'h00 :
                        8'(ctrl_q[`ESF_CTRL_DIV_HI:`ESF_CTRL_DIV_LO] - 8'h01);
   assign paused      = ~hold_n_q | ctrl_q[`ESF_CTRL_HOLD];
   assign f_out_ready = (st_q == ESF_IDLE) & ~cs_n_q & ~paused;
   assign rx_done     = (st_q == ESF_HIGH) & (cnt_q >= half_m1) & (bit_q == 3'h0);

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         st_q   <= ESF_IDLE;
         cnt_q  <= 8'h00;
         bit_q  <= 3'h0;
         sh_q   <= 8'h00;
         rx_q   <= 8'h00;
         sck_q  <= 1'b0;
         mosi_q <= 1'b0;
      end else begin
         unique case (st_q)
            ESF_IDLE: begin
               sck_q <= ctrl_q[`ESF_CTRL_CPOL];
               if (f_out_ready && f_out_valid) begin
                  st_q   <= ESF_LOW;
                  sck_q  <= 1'b0;
                  cnt_q  <= 8'h00;
                  bit_q  <= 3'h7;
                  sh_q   <= f_out_data;
                  mosi_q <= f_out_data[7];
               end
            end
            ESF_LOW: begin
               // a pause restarts the low half: the device needs time to drive again
               if (paused) begin
                  cnt_q <= 8'h00;
               end else if (cnt_q < half_m1) begin
                  cnt_q <= 8'(cnt_q + 8'h01);
               end else begin
                  // rising edge: device captures mosi, miso is sampled here
                  st_q  <= ESF_HIGH;
                  sck_q <= 1'b1;
                  cnt_q <= 8'h00;
                  rx_q  <= {rx_q[6:0], ms2_q};
               end
            end
            ESF_HIGH: begin
               if (cnt_q < half_m1) begin
                  cnt_q <= 8'(cnt_q + 8'h01);
               end else if (bit_q == 3'h0) begin
                  st_q  <= ESF_IDLE;
                  sck_q <= ctrl_q[`ESF_CTRL_CPOL];
               end else begin
                  st_q   <= ESF_LOW;
                  sck_q  <= 1'b0;
                  cnt_q  <= 8'h00;
                  bit_q  <= 3'(bit_q - 3'h1);
                  sh_q   <= {sh_q[6:0], 1'b0};
                  mosi_q <= sh_q[6];
               end
            end
            default: st_q <= ESF_IDLE;
         endcase
      end
   end

   assign spi.sck    = sck_q;
   assign spi.cs_n   = cs_n_q;
   assign spi.mosi   = mosi_q;
   assign spi.hold_n = hold_n_q;
   assign spi.wp_n   = wp_n_q;
endmodule : esf_host

// [rtl/esf_pkg.sv]
package esf_pkg;
   // ========================================================================
   // types
   typedef logic [7:0] esf_byte_t;
   typedef enum logic [1:0] {
      ESF_IDLE = 2'b00,
      ESF_LOW  = 2'b01,
      ESF_HIGH = 2'b10
   } esf_eng_t;
endpackage : esf_pkg

// [rtl/esf_regs.svh]
`ifndef ESF_REGS_SVH
`define ESF_REGS_SVH
// ==========================================================================
// controller register map (byte offsets, low address byte)
`define ESF_CTRL_OFS    8'h00
`define ESF_STAT_OFS    8'h04
`define ESF_TXD_OFS     8'h08
`define ESF_RXD_OFS     8'h0C
// ==========================================================================
// control fields
`define ESF_CTRL_CS     0
`define ESF_CTRL_CPOL   1
`define ESF_CTRL_HOLD   2
`define ESF_CTRL_WP     3
`define ESF_CTRL_DIV_LO 8
`define ESF_CTRL_DIV_HI 15
`define ESF_CTRL_MASK   32'h0000FF0F
// ==========================================================================
// status fields
`define ESF_STAT_BUSY   0
`define ESF_STAT_EMPTY  1
`define ESF_STAT_FULL   2
`define ESF_STAT_RXRDY  3
// ==========================================================================
// timing: half period of the serial clock
`define ESF_HCLK_NS     5
`define ESF_SCK_HALF_NS 40
`define ESF_HALF_CYC    ((`ESF_SCK_HALF_NS + `ESF_HCLK_NS - 1) / `ESF_HCLK_NS)
`define ESF_CTRL_RST    (32'h00000008 | (`ESF_HALF_CYC << `ESF_CTRL_DIV_LO))
`define ESF_FIFO_DEPTH  32
`endif

// [rtl/esf_spi_if.sv]
`timescale 1ns/1ps
interface esf_spi_if;
   logic sck;
   logic cs_n;
   logic mosi;
   logic miso;
   logic miso_oe;
   logic hold_n;
   logic wp_n;
   modport host (output sck, output cs_n, output mosi, output hold_n, output wp_n,
                 input miso, input miso_oe);
   modport dev  (input sck, input cs_n, input mosi, input hold_n, input wp_n,
                 output miso, output miso_oe);
endinterface : esf_spi_if

// [test/esf_checker.sv]
`timescale 1ns/1ps
module esf_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic sck,
   input wire logic cs_n,
   input wire logic mosi,
   input wire logic miso,
   input wire logic miso_oe,
   input wire logic hold_n,
   input wire logic wp_n
);
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);
   // ====================
   // link assertions
   hiz_desel_a: assert property (cs_n [*6] |-> !miso_oe)
      else $error("output driven while deselected");
   hiz_pause_a: assert property (!hold_n [*6] |-> !miso_oe)
      else $error("output driven while paused");
   out_fall_a: assert property (miso_oe && $changed(miso) |-> !sck)
      else $error("output changed with clock high");
   in_stable_a: assert property (!cs_n && sck && $past(sck) |-> $stable(mosi))
      else $error("input data moved with clock high");
   wp_steady_a: assert property (!cs_n && !$past(cs_n) |-> $stable(wp_n))
      else $error("write protect moved while selected");
   pause_edge_a: assert property ($changed(hold_n) |-> !sck && !cs_n)
      else $error("pause edge outside selected low clock");
   oe_start_a: assert property ($rose(miso_oe) |-> !cs_n && hold_n)
      else $error("output enabled without selection");
   rst_quiet_a: assert property (!$past(hresetn) |-> !miso_oe && cs_n && hold_n)
      else $error("link not quiet after reset");
   // ====================
   // covers
   cover property (!miso_oe ##1 miso_oe);
   cover property ($fell(hold_n));
   cover property ($fell(cs_n) && sck);
endmodule : esf_checker

// [test/tb_top.sv]
`timescale 1ns/1ps
`include "esf_regs.svh"
module tb_top import esf_pkg::*;;
   logic        hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, hreadyout, rx_valid, rx_first;
   logic [31:0] haddr = 0, hwdata = 0, hrdata, last_rd;
   logic [1:0]  htrans = 0, wr_addr_hi = 0;
   esf_byte_t   rx_byte, tx_byte = 8'h6B, rxq[$];
   logic        tx_start = 0, wel_set = 0, wel_clr = 0, busy_set = 0, busy_clr = 0;
   logic        write_enable_latch, write_busy_flag, standby, wr_blocked, status_locked, held;
   logic        status_write_disable = 0, protect_sel_hi = 0, protect_sel_lo = 0;
   int          fails = 0, comparisons = 0;
   esf_spi_if spi_bus();
   always #2.5 hclk = ~hclk;
   esf_host u_esf_host (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize(3'h2),
      .hwdata, .hready(hreadyout), .hreadyout, .hresp(), .hrdata, .spi(spi_bus.host));
   esf_dev u_esf_dev (.hclk, .hresetn, .spi(spi_bus.dev), .rx_byte, .rx_valid, .rx_first,
      .sel_start(), .sel_end(), .selected(), .held, .standby, .tx_byte, .tx_start,
      .tx_take(), .wel_set, .wel_clr, .busy_set, .busy_clr, .write_enable_latch,
      .write_busy_flag, .status_write_disable, .protect_sel_hi, .protect_sel_lo,
      .wr_addr_hi, .wr_blocked, .status_locked);
   esf_checker u_esf_checker (.hclk, .hresetn, .sck(spi_bus.sck), .cs_n(spi_bus.cs_n),
      .mosi(spi_bus.mosi), .miso(spi_bus.miso), .miso_oe(spi_bus.miso_oe),
      .hold_n(spi_bus.hold_n), .wp_n(spi_bus.wp_n));
   // ====================
   // device user side: answer the first byte
   always @(posedge hclk) begin
      if (rx_valid === 1'b1)
         rxq.push_back(rx_byte);
      tx_start <= rx_valid & rx_first;
   end
   // ====================
   // tasks
   task automatic conclude();
      $display("comparisons %0d fails %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : conclude
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask : chk
   task automatic to_out();
      fails++;
      $display("MISMATCH %0t wait limit", $time);
      conclude();
   endtask : to_out
   // hreadyout is combinational: look at it away from the edge
   task automatic wait_rdy();
      int n;
      n = 0;
      @(negedge hclk);
      while (hreadyout !== 1'b1) begin
         @(negedge hclk);
         n++;
         if (n > 3000)
            to_out();
      end
      last_rd = hrdata;
      @(posedge hclk);
   endtask : wait_rdy
   task automatic ahb(input logic w, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      htrans <= 2'h2;
      haddr <= a;
      hwrite <= w;
      wait_rdy();
      htrans <= 2'h0;
      hwdata <= d;
      wait_rdy();
   endtask : ahb
   task automatic rd_chk(input logic [31:0] a, input logic [31:0] exp, input string m);
      ahb(1'b0, a, 32'h0);
      chk(last_rd, exp, m);
   endtask : rd_chk
   task automatic drain();
      int n;
      n = 0;
      do begin
         ahb(1'b0, `ESF_STAT_OFS, 32'h0);
         n++;
         if (n > 5000)
            to_out();
      end while (last_rd[0] !== 1'b0);
   endtask : drain
   // ====================
   // main sequence
   initial begin
      repeat (16) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      chk(standby, 1'b1, "standby");
      chk(write_busy_flag | write_enable_latch, 1'b0, "flags");
      rd_chk(`ESF_CTRL_OFS, `ESF_CTRL_RST, "ctrl");
      rd_chk(`ESF_STAT_OFS, 32'h2, "status");
      ahb(1'b1, 32'h10, 32'hFFFFFFFF);
      rd_chk(32'h10, 32'h0, "unmapped");
      busy_set <= 1'b1;
      @(posedge hclk);
      busy_set <= 1'b0;
      repeat (3) @(posedge hclk);
      chk(standby, 1'b0, "busy standby");
      busy_clr <= 1'b1;
      @(posedge hclk);
      busy_clr <= 1'b0;
      {wel_set, wel_clr} <= 2'b11;
      @(posedge hclk);
      {wel_set, wel_clr} <= 2'b00;
      repeat (2) @(posedge hclk);
      chk(write_enable_latch, 1'b1, "set wins");
      wel_clr <= 1'b1;
      @(posedge hclk);
      wel_clr <= 1'b0;
      repeat (2) @(posedge hclk);
      chk(write_enable_latch, 1'b0, "latch clr");
      for (int i = 0; i < 16; i++) begin
         {protect_sel_hi, protect_sel_lo, wr_addr_hi} <= i[3:0];
         repeat (3) @(posedge hclk);
         chk(wr_blocked, i[3:2] == 3 || i[3:2] == 2 && i[1] || i == 7, "block");
      end
      status_write_disable <= 1'b1;
      ahb(1'b1, `ESF_CTRL_OFS, 32'h0800);
      repeat (6) @(posedge hclk);
      chk(status_locked, 1'b1, "locked");
      ahb(1'b1, `ESF_CTRL_OFS, 32'h0808);
      repeat (6) @(posedge hclk);
      chk(status_locked, 1'b0, "unlocked");
      for (int m = 0; m < 2; m++) begin
         tx_byte <= m ? 8'hD4 : 8'h6B;
         rxq.delete();
         ahb(1'b1, `ESF_CTRL_OFS, 32'h0808 | (m << 1));
         ahb(1'b1, `ESF_CTRL_OFS, 32'h0809 | (m << 1));
         ahb(1'b1, `ESF_TXD_OFS, 32'hA5);
         ahb(1'b1, `ESF_TXD_OFS, 32'h3C);
         ahb(1'b1, `ESF_CTRL_OFS, 32'h080D | (m << 1));
         repeat (40) @(posedge hclk);
         chk(held, 1'b1, "held");
         chk(standby, 1'b0, "active");
         ahb(1'b1, `ESF_CTRL_OFS, 32'h0809 | (m << 1));
         drain();
         chk(held, 1'b0, "resumed");
         ahb(1'b1, `ESF_CTRL_OFS, 32'h0808 | (m << 1));
         chk(rxq.size(), 2, "count");
         chk(rxq[0], 8'hA5, "rx first");
         chk(rxq[1], 8'h3C, "rx second");
         rd_chk(`ESF_RXD_OFS, m ? 32'hD4 : 32'h6B, "tx byte");
      end
      rxq.delete();
      for (int i = 0; i < 32; i++)
         ahb(1'b1, `ESF_TXD_OFS, i);
      rd_chk(`ESF_STAT_OFS, 32'h5, "full");
      ahb(1'b1, `ESF_CTRL_OFS, 32'h080B);
      drain();
      ahb(1'b1, `ESF_CTRL_OFS, 32'h080A);
      chk(rxq.size(), 32, "fifo count");
      chk(rxq[31], 8'h1F, "fifo last");
      conclude();
   end
endmodule : tb_top
